// [logic/gst_timer.sv]
// Function
// - Three modes: prescaled timer, synchronous counter, asynchronous counter.
// - Timer mode advances once per instruction cycle, via prescaler and gate.
// - Counter mode advances on external input rising edges, after the prescaler.
// - Counter mode input is resynchronised or free running per sync control.
// - Active-low gate input may gate counting in both modes.
// - Crystal oscillator can clock the counter when internal oscillator runs.
// - First counted rising edge must follow a detected falling edge.
// - Sixteen-bit count goes up and wraps from all ones to zero.
// - Every wrap sets overflow flag at request register bit 0.
// - Interrupt only with overflow, peripheral bit 6 and global bit 7 enables.
// - Overflow flag stays set until software writes it to zero.
// - Prescaler divides by 1, 2, 4 or 8 from control bits 5:4.
// - Prescaler is hidden and cleared on any count byte write.
// - Count is readable and writable as high and low bytes.
// - Asynchronous counter overflow can wake the device from sleep.
// - Control at 0x10, bit 7 reads zero, bits 6:0 read/write reset zero.
// - With gate enable set and timer on, count only while gate pin low.
// - Prescale codes 11=1:8, 10=1:4, 01=1:2, 00=1:1.
// - External source: sync bit 1 free runs, 0 synchronises; ignored internally.
// - Source bit 1 counts external rising edges, 0 counts quarter oscillator.
`include "gst_params.svh"

module gst_timer #(
   parameter int CNT_W  = 16,
   parameter int PRE_W  = 3
) (
   input  wire logic       CORE_CLK,
   input  wire logic       RST,
   input  wire logic [7:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR_STB,
   input  wire logic       RD_STB,
   output logic      [7:0] RDATA,
   input  wire logic       EXTERNAL_COUNT_INPUT,
   input  wire logic       LOW_POWER_CRYSTAL_CLK,
   input  wire logic       COUNT_GATE_N,
   input  wire logic       INTERNAL_OSC_NO_CLKOUT,
   input  wire logic       SLEEP,
   output logic            IRQ,
   output logic            WAKE,
   output logic            CRYSTAL_OSC_ON
);

   // ----------------------------------------------------------------------
   // Register bus decode
   // ----------------------------------------------------------------------
   gst_pkg::gst_bus_type bus;
   assign bus = '{addr: ADDR, wdata: WDATA, wr: WR_STB, rd: RD_STB};

   wire sel_ctrl  = (bus.addr == `GST_OFS_TIMER_CTRL);
   wire sel_low   = (bus.addr == `GST_OFS_COUNT_LOW);
   wire sel_high  = (bus.addr == `GST_OFS_COUNT_HIGH);
   wire sel_req   = (bus.addr == `GST_OFS_PERIPH_REQ);
   wire sel_pen   = (bus.addr == `GST_OFS_PERIPH_EN);
   wire sel_intc  = (bus.addr == `GST_OFS_INT_CTRL);

   wire wr_ctrl   = bus.wr & sel_ctrl;
   wire wr_low    = bus.wr & sel_low;
   wire wr_high   = bus.wr & sel_high;
   wire wr_req    = bus.wr & sel_req;
   wire wr_pen    = bus.wr & sel_pen;
   wire wr_intc   = bus.wr & sel_intc;

   // ----------------------------------------------------------------------
   // Stored state
   // ----------------------------------------------------------------------
   gst_pkg::gst_ctrl_type ctrl_q;
   gst_pkg::gst_ctrl_type ctrl_d;
   logic [CNT_W-1:0]      count_q;
   logic [CNT_W-1:0]      count_d;
   logic [PRE_W-1:0]      pre_q;
   logic [PRE_W-1:0]      pre_d;
   logic [1:0]            phase_q;
   logic                  ovf_flag_q;
   logic                  ovf_flag_d;
   logic                  ovf_en_q;
   logic                  periph_en_q;
   logic                  global_en_q;
   logic                  armed_q;
   logic                  armed_d;
   logic [7:0]            rdata_q;
   logic [7:0]            rdata_d;
   logic                  irq_q;
   logic                  wake_q;
   logic                  osc_on_q;

   // Bit 7 is not stored; it reads zero
   assign ctrl_d = wr_ctrl ? gst_pkg::gst_ctrl_type'({1'b0, bus.wdata[6:0]}) : ctrl_q;

   // ----------------------------------------------------------------------
   // Instruction cycle tick
   // ----------------------------------------------------------------------
   localparam logic [1:0] PHASE_LAST = 2'(`GST_CLK_PER_INSTR - 1);

   // The core stops in sleep, so no instruction ticks then
   wire instr_tick = (phase_q == PHASE_LAST) & ~SLEEP;

   // ----------------------------------------------------------------------
   // Clock source selection
   // ----------------------------------------------------------------------
   wire ext_mode   = ctrl_q.clock_source_select;
   wire osc_active = ctrl_q.crystal_osc_enable & INTERNAL_OSC_NO_CLKOUT;
   wire ext_level  = osc_active ? LOW_POWER_CRYSTAL_CLK : EXTERNAL_COUNT_INPUT;
   wire use_sync   = ~ctrl_q.sync_disable;
   wire ext_rise;
   wire ext_fall;

   gst_edge u_edge (
      .clk         (CORE_CLK),
      .rst         (RST),
      .din         (ext_level),
      .use_sync    (use_sync),
      .sample_tick (instr_tick),
      .rise        (ext_rise),
      .fall        (ext_fall)
   );

   // A rising edge only counts once a falling edge has been seen
   assign armed_d = (~ext_mode | ~ctrl_q.timer_on) ? 1'b0 :
                    (ext_fall ? 1'b1 : armed_q);
   wire ext_tick  = ext_rise & armed_q;

   // Synchronised counting needs the core clock phases, so it halts in sleep
   wire ext_ok    = ~(SLEEP & use_sync);
   wire src_tick  = ext_mode ? (ext_tick & ext_ok) : instr_tick;

   // ----------------------------------------------------------------------
   // Gate and prescaler
   // ----------------------------------------------------------------------
   wire gate_open = ~ctrl_q.gate_enable | ~COUNT_GATE_N;
   wire count_en  = ctrl_q.timer_on & gate_open;
   wire gated     = src_tick & count_en;

   gst_pkg::gst_div_type div_sel;
   assign div_sel = gst_pkg::gst_div_type'({ctrl_q.prescale_select_hi,
                                            ctrl_q.prescale_select_lo});

   logic [PRE_W-1:0] pre_mask;
   always_comb begin
      case (div_sel)
         gst_pkg::GST_DIV1: pre_mask = PRE_W'(0);
         gst_pkg::GST_DIV2: pre_mask = PRE_W'(1);
         gst_pkg::GST_DIV4: pre_mask = PRE_W'(3);
         gst_pkg::GST_DIV8: pre_mask = PRE_W'(7);
         default:           pre_mask = PRE_W'(0);
      endcase
   end

   wire pre_full  = ((pre_q & pre_mask) == pre_mask);
   wire inc       = gated & pre_full;
   wire count_wr  = wr_low | wr_high;

   // Any count byte write restarts the division
   assign pre_d = count_wr ? '0 : (gated ? pre_q + PRE_W'(1) : pre_q);

   // ----------------------------------------------------------------------
   // Counter and overflow
   // ----------------------------------------------------------------------
   // A software write wins over a simultaneous increment: stop the timer first
   wire [CNT_W-1:0] count_inc = count_q + CNT_W'(1);
   wire             wrap      = inc & (count_q == `GST_COUNT_ALL_ONES) & ~count_wr;

   always_comb begin
      count_d = count_q;
      if (wr_low) begin
         count_d[7:0] = bus.wdata;
      end else if (wr_high) begin
         count_d[CNT_W-1:8] = bus.wdata[CNT_W-9:0];
      end else if (inc) begin
         count_d = count_inc;
      end
   end

   // Overflow set beats a clear landing in the same cycle
   assign ovf_flag_d = wrap | (wr_req ? bus.wdata[`GST_BIT_OVF_FLAG] : ovf_flag_q);

   wire irq_d  = ovf_flag_q & ovf_en_q & periph_en_q & global_en_q;
   // Wake needs both local enables but not the global one
   wire wake_d = SLEEP & ovf_flag_q & ovf_en_q & periph_en_q & ctrl_q.timer_on;

   // ----------------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------------
   always_comb begin
      rdata_d = `GST_RST_BYTE;
      if (bus.rd) begin
         if (sel_ctrl) begin
            rdata_d = {1'b0, ctrl_q[6:0]};
         end else if (sel_low) begin
            rdata_d = count_q[7:0];
         end else if (sel_high) begin
            rdata_d = count_q[CNT_W-1:8];
         end else if (sel_req) begin
            rdata_d = {7'h00, ovf_flag_q};
         end else if (sel_pen) begin
            rdata_d = {7'h00, ovf_en_q};
         end else if (sel_intc) begin
            rdata_d = {global_en_q, periph_en_q, 6'h00};
         end else begin
            rdata_d = `GST_RST_BYTE;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Flip-flops
   // ----------------------------------------------------------------------
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         ctrl_q <= gst_pkg::gst_ctrl_type'(`GST_RST_TIMER_CTRL);
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         count_q <= `GST_RST_COUNT;
      end else begin
         count_q <= count_d;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         pre_q <= '0;
      end else begin
         pre_q <= pre_d;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         phase_q <= 2'h0;
      end else begin
         phase_q <= SLEEP ? 2'h0 : phase_q + 2'h1;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         armed_q <= 1'b0;
      end else begin
         armed_q <= armed_d;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         ovf_flag_q <= 1'b0;
      end else begin
         ovf_flag_q <= ovf_flag_d;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         ovf_en_q <= 1'b0;
      end else begin
         ovf_en_q <= wr_pen ? bus.wdata[`GST_BIT_OVF_EN] : ovf_en_q;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         periph_en_q <= 1'b0;
      end else begin
         periph_en_q <= wr_intc ? bus.wdata[`GST_BIT_PERIPH_IRQ_EN] : periph_en_q;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         global_en_q <= 1'b0;
      end else begin
         global_en_q <= wr_intc ? bus.wdata[`GST_BIT_GLOBAL_IRQ_EN] : global_en_q;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         rdata_q <= `GST_RST_BYTE;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         wake_q <= 1'b0;
      end else begin
         wake_q <= wake_d;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         osc_on_q <= 1'b0;
      end else begin
         osc_on_q <= osc_active;
      end
   end

   assign RDATA          = rdata_q;
   assign IRQ            = irq_q;
   assign WAKE           = wake_q;
   assign CRYSTAL_OSC_ON = osc_on_q;

endmodule

// [logic/gst_params.svh]
`ifndef GST_PARAMS_SVH
`define GST_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define GST_ADDR_W            8
`define GST_OFS_INT_CTRL      8'h0B
`define GST_OFS_PERIPH_REQ    8'h0C
`define GST_OFS_COUNT_LOW     8'h0E
`define GST_OFS_COUNT_HIGH    8'h0F
`define GST_OFS_TIMER_CTRL    8'h10
`define GST_OFS_PERIPH_EN     8'h8C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define GST_BIT_OVF_FLAG      0
`define GST_BIT_OVF_EN        0
`define GST_BIT_PERIPH_IRQ_EN 6
`define GST_BIT_GLOBAL_IRQ_EN 7

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define GST_RST_TIMER_CTRL    8'h00
`define GST_RST_BYTE          8'h00
`define GST_RST_COUNT         16'h0000
`define GST_COUNT_ALL_ONES    16'hFFFF
`define GST_CLK_PER_INSTR     4

`endif

// [logic/gst_pkg.sv]
package gst_pkg;

   typedef struct packed {
      logic       unused;
      logic       gate_enable;
      logic       prescale_select_hi;
      logic       prescale_select_lo;
      logic       crystal_osc_enable;
      logic       sync_disable;
      logic       clock_source_select;
      logic       timer_on;
   } gst_ctrl_type;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } gst_bus_type;

   typedef enum logic [1:0] {
      GST_DIV1 = 2'b00,
      GST_DIV2 = 2'b01,
      GST_DIV4 = 2'b10,
      GST_DIV8 = 2'b11
   } gst_div_type;

endpackage

// [logic/gst_edge.sv]
// ----------------------------------------------------------------------
// Count input edge finder
// ----------------------------------------------------------------------
module gst_edge (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic din,
   input  wire logic use_sync,
   input  wire logic sample_tick,
   output logic      rise,
   output logic      fall
);
   logic meta_q;
   logic stable_q;
   logic level_q;
   logic prev_q;
   logic level_d;

   // Synchronised mode only moves at instruction boundaries
   assign level_d = (!use_sync || sample_tick) ? stable_q : level_q;
   assign rise    = level_q & ~prev_q;
   assign fall    = ~level_q & prev_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q   <= 1'b0;
         stable_q <= 1'b0;
         level_q  <= 1'b0;
         prev_q   <= 1'b0;
      end else begin
         meta_q   <= din;
         stable_q <= meta_q;
         level_q  <= level_d;
         prev_q   <= level_q;
      end
   end
endmodule

// [sim/gst_timer_monitor.sv]
// -------------------
// Port checker
// -------------------
module gst_timer_monitor (
   input wire logic       CORE_CLK,
   input wire logic       RST,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic       WR_STB,
   input wire logic       RD_STB,
   input wire logic [7:0] RDATA,
   input wire logic       IRQ,
   input wire logic       WAKE,
   input wire logic       SLEEP,
   input wire logic       CRYSTAL_OSC_ON
);
   timeunit 1ns;
   timeprecision 1ps;
   // Software view only; enables are global, peripheral, overflow
   logic [7:0] ctrl_q;
   logic [2:0] en_q;
   wire        mapped = ADDR inside {8'h0B, 8'h0C, 8'h0E, 8'h0F, 8'h10, 8'h8C};
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         ctrl_q <= 8'h00;
         en_q   <= 3'h0;
      end else if (WR_STB) begin
         if (ADDR == 8'h10) ctrl_q <= WDATA;
         if (ADDR == 8'h0B) en_q[2:1] <= WDATA[7:6];
         if (ADDR == 8'h8C) en_q[0] <= WDATA[0];
      end
   end
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   sequence read_of(logic [7:0] a);
      (RD_STB && ADDR == a) ##1 1'b1;
   endsequence
   // A flag clear one cycle earlier would legally beat the stale request
   sequence flag_read;
      !WR_STB ##1 (RD_STB && ADDR == 8'h0C && IRQ) ##1 1'b1;
   endsequence
   AST_RDATA_IDLE: assert property (!$past(RD_STB) |-> RDATA == 8'h00)
      else $error("read data without a read");
   AST_CTRL_READ: assert property (read_of(8'h10) |-> RDATA == {1'b0, ctrl_q[6:0]})
      else $error("control read back wrong");
   AST_UNMAPPED: assert property ((RD_STB && !mapped) ##1 1'b1 |-> RDATA == 8'h00)
      else $error("unmapped read not zero");
   AST_FLAG_IRQ: assert property (flag_read |-> RDATA[0])
      else $error("request without flag");
   AST_IRQ_EN: assert property (IRQ |-> $past(en_q) == 3'h7)
      else $error("request while disabled");
   AST_IRQ_HOLD: assert property (IRQ && en_q == 3'h7 && !$past(WR_STB && ADDR == 8'h0C)
      |=> IRQ)
      else $error("request dropped by itself");
   AST_WAKE: assert property (WAKE |-> $past(SLEEP && en_q[1:0] == 2'h3 && ctrl_q[0]))
      else $error("wake without its enables");
   AST_OSC: assert property (CRYSTAL_OSC_ON |-> $past(ctrl_q[3]))
      else $error("oscillator on while disabled");
endmodule

// [sim/gst_source.sv]
// -------------------
// Count clock source
// -------------------
module gst_source (
   output logic ext_clk,
   output logic xtal_clk
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {xtal_clk, ext_clk} = 2'b00;
   // Starts low; the first burst whose edges reach the counter after it is enabled loses its first rise
   // Odd half period keeps every level change off the core clock edges
   task automatic burst(input int n, input logic use_xtal);
      repeat (n) begin
         #333 {xtal_clk, ext_clk} = use_xtal ? 2'b10 : 2'b01;
         #333 {xtal_clk, ext_clk} = 2'b00;
      end
   endtask
endmodule

// [sim/testbench.sv]
// -------------------
// Timer bench
// -------------------
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdat = 8'h00;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic       gate_n = 1'b1;
   logic       sleep = 1'b0;
   logic       internal_oscillator = 1'b1;
   logic       ext;
   logic       xtal;
   logic [7:0] rdat;
   logic       irq;
   logic       wake;
   logic       osc_on;
   int         miscompares = 0;
   int         checked = 0;
   always #20 clk = ~clk;
   gst_source src_u (.ext_clk(ext), .xtal_clk(xtal));
   gst_timer dut_u (.CORE_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdat), .WR_STB(wr),
      .RD_STB(rd), .RDATA(rdat), .EXTERNAL_COUNT_INPUT(ext), .LOW_POWER_CRYSTAL_CLK(xtal),
      .COUNT_GATE_N(gate_n), .INTERNAL_OSC_NO_CLKOUT(internal_oscillator), .SLEEP(sleep), .IRQ(irq),
      .WAKE(wake), .CRYSTAL_OSC_ON(osc_on));
   task automatic report_and_stop();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Tick phase is free running, so timed counts allow one step of slack
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input int tol = 0);
      checked++;
      if ($isunknown(got) || got + tol < exp || got > exp + tol) begin
         miscompares++;
         $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      addr <= a;
      wdat <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd8(input logic [7:0] a, output logic [7:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdat;
      @(posedge clk);
   endtask
   task automatic chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      rd8(a, v);
      cmp({8'h00, v}, {8'h00, e});
   endtask
   task automatic chk16(input logic [15:0] e, input int tol);
      logic [15:0] c;
      rd8(8'h0E, c[7:0]);
      rd8(8'h0F, c[15:8]);
      cmp(c, e, tol);
   endtask
   task automatic see(ref logic s, input logic e);
      #1 cmp({15'h0000, s}, {15'h0000, e});
      @(posedge clk);
   endtask
   task automatic wait_hi(ref logic s);
      for (int i = 0; i < 500 && s !== 1'b1; i++) @(posedge clk);
   endtask
   task automatic set_cnt(input logic [7:0] v);
      wr8(8'h0E, v);
      wr8(8'h0F, v);
   endtask
   task automatic t_regs();
      chk(8'h10, 8'h00);
      chk16(16'h0000, 0);
      wr8(8'h10, 8'hFE);
      chk(8'h10, 8'h7E);
      wr8(8'h55, 8'hAA);
      chk(8'h55, 8'h00);
      wr8(8'h0E, 8'hA5);
      wr8(8'h0F, 8'h5A);
      chk16(16'h5AA5, 0);
      wr8(8'h10, 8'h00);
      $display("registers done");
   endtask
   task automatic t_prescale();
      for (int p = 0; p < 4; p++) begin
         set_cnt(8'h00);
         wr8(8'h10, {2'b00, p[1:0], 4'h1});
         repeat (32 << p) @(posedge clk);
         wr8(8'h10, 8'h00);
         chk16(16'h0008, 1);
      end
      $display("prescale done");
   endtask
   task automatic t_gate();
      set_cnt(8'h00);
      wr8(8'h10, 8'h41);
      repeat (62) @(posedge clk);
      wr8(8'h10, 8'h40);
      chk16(16'h0000, 0);
      gate_n <= 1'b0;
      wr8(8'h10, 8'h41);
      repeat (62) @(posedge clk);
      wr8(8'h10, 8'h40);
      chk16(16'h0010, 1);
      $display("gate done");
   endtask
   task automatic t_ovf();
      wr8(8'h0C, 8'h00);
      set_cnt(8'hFF);
      wr8(8'h8C, 8'h01);
      wr8(8'h0B, 8'hC0);
      wr8(8'h10, 8'h01);
      wait_hi(irq);
      see(irq, 1'b1);
      wr8(8'h10, 8'h00);
      chk16(16'h0000, 1);
      see(irq, 1'b1);
      chk(8'h0C, 8'h01);
      wr8(8'h0C, 8'h00);
      see(irq, 1'b0);
      wr8(8'h0B, 8'h40);
      set_cnt(8'hFF);
      wr8(8'h10, 8'h01);
      repeat (8) @(posedge clk);
      wr8(8'h10, 8'h00);
      see(irq, 1'b0);
      chk(8'h0C, 8'h01);
      wr8(8'h0C, 8'h00);
      $display("overflow done");
   endtask
   task automatic t_ext(input logic [7:0] ctl, input logic x);
      set_cnt(8'h00);
      wr8(8'h10, ctl);
      src_u.burst(5, x);
      @(posedge clk);
      if (x) begin
         see(osc_on, 1'b1);
         internal_oscillator <= 1'b0;
         @(posedge clk);
         see(osc_on, 1'b0);
         internal_oscillator <= 1'b1;
      end
      wr8(8'h10, 8'h00);
      chk16(16'h0004, 0);
      $display("external count done");
   endtask
   task automatic t_clear();
      set_cnt(8'h00);
      wr8(8'h10, 8'h17);
      src_u.burst(2, 1'b0);
      @(posedge clk);
      chk16(16'h0000, 0);
      wr8(8'h0E, 8'h00);
      src_u.burst(1, 1'b0);
      @(posedge clk);
      chk16(16'h0000, 0);
      src_u.burst(1, 1'b0);
      @(posedge clk);
      wr8(8'h10, 8'h00);
      chk16(16'h0001, 0);
      $display("prescaler clear done");
   endtask
   task automatic t_sleep();
      set_cnt(8'hFF);
      sleep <= 1'b1;
      wr8(8'h10, 8'h03);
      src_u.burst(3, 1'b0);
      @(posedge clk);
      wr8(8'h10, 8'h07);
      chk16(16'hFFFF, 0);
      src_u.burst(2, 1'b0);
      wait_hi(wake);
      see(wake, 1'b1);
      see(irq, 1'b0);
      sleep <= 1'b0;
      wr8(8'h10, 8'h00);
      chk(8'h0C, 8'h01);
      $display("sleep done");
   endtask
   // Run needs about 1250 cycles; allow eight times that
   initial begin
      #400000;
      miscompares++;
      report_and_stop();
   end
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_prescale();
      t_gate();
      t_ovf();
      t_ext(8'h03, 1'b0);
      t_ext(8'h07, 1'b0);
      t_ext(8'h0B, 1'b1);
      t_clear();
      t_sleep();
      report_and_stop();
   end
endmodule
bind gst_timer gst_timer_monitor mon_u (.CORE_CLK(CORE_CLK), .RST(RST), .ADDR(ADDR),
   .WDATA(WDATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA), .IRQ(IRQ),
   .WAKE(WAKE), .SLEEP(SLEEP), .CRYSTAL_OSC_ON(CRYSTAL_OSC_ON));
